/* File: src/devctl_defines.vh */
// offsets, field positions and reset values of the device control/status pair
// included by the register bank only; the pin synchroniser does not include it
`ifndef DEVCTL_DEFINES_VH
`define DEVCTL_DEFINES_VH
`define OFS_DEVICE_CONTROL 12'h0e8
`define OFS_DEVICE_STATUS 12'h0ea
`define CTL_CORR_EN 0
`define CTL_NONFATAL_EN 1
`define CTL_FATAL_EN 2
`define CTL_UR_EN 3
`define CTL_RELAXED_EN 4
`define CTL_PAYLOAD_LO 5
`define CTL_PAYLOAD_HI 7
`define CTL_EXT_TAG 8
`define CTL_PHANTOM 9
`define CTL_AUX_PM 10
`define CTL_NO_SNOOP 11
`define CTL_READREQ_LO 12
`define CTL_READREQ_HI 14
`define STS_CORR 0
`define STS_NONFATAL 1
`define STS_FATAL 2
`define STS_UR 3
`define STS_AUX_POWER 4
`define STS_PENDING 5
`define STS_LANE_LO 16
`define RST_ERR_EN 4'h0
`define RST_RELAXED_EN 1'h1
`define RST_PAYLOAD 3'h0
`define RST_EXT_TAG 1'h0
`define RST_PHANTOM 1'h0
`define RST_NO_SNOOP 1'h1
`define RST_READREQ 3'h2
`define RST_PAYLOAD_CAP 3'h1
`endif

/* File: src/pin_sync.v */
// three-stage synchroniser with second/third agreement
// assumes pin input is asynchronous to clock
`timescale 1ns/100ps
module pin_sync #(
    parameter RESET_VAL = 1'b0
) (
    // clock
    input wire clock,
    input wire rst,
    // pin and result
    input wire pin,
    output reg level_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge clock) begin
        if (rst) begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
            level_r <= RESET_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule // pin_sync

/* File: src/pcie_device_control_status.v */
// device control and device status configuration registers
// config port accesses 32-bit dwords with byte enables, read data registered
//
// Behaviour
// [R1] control bits 0..3 are error reporting enables, reset to zero
// [R2] bit 4 relaxed ordering enable, resets one, gates the relaxed attribute
// [R3] payload field 7:5 resets to 128 bytes, limits transmitted payload
// [R4] receiver accepts payloads up to the programmed payload size
// [R5] software programs payload no larger than the advertised capability
// [R6] bits 8 and 9 are plain storage resetting to zero, no effect
// [R7] bit 10 reads zero, writes ignored
// [R8] bit 11 no snoop enable, resets one, further gated by global select
// [R9] read request field 14:12 resets to 512 bytes, limits read requests
// [R10] software should not change read request size while reads are active
// [R11] status bits 0..2 set on detected errors, write one to clear
// [R12] status bit 3 set on unsupported request, write one to clear
// [R13] status bit 4 follows aux power strap, reset by power on only
// [R14] status bit 5 reads one while non-posted requests await completion
// [R15] advertised payload capability defaults to 256, loadable from nvm
// [R16] reserved bits read zero; detected bits set regardless of enables
`timescale 1ns/100ps
`include "devctl_defines.vh"
module pcie_device_control_status (
    // clock and resets
    input wire clock,
    input wire rst,
    input wire power_on_rst,
    // configuration access, byte address, low two bits ignored
    input wire cfg_req,
    input wire cfg_wr,
    input wire [11:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_ack,
    // error events, one-cycle pulses
    input wire err_corr,
    input wire err_nonfatal,
    input wire err_fatal,
    input wire err_unsupported,
    // device state
    input wire aux_power_pin,
    input wire np_pending,
    input wire nvm_cap_load,
    input wire [2:0] nvm_payload_cap,
    input wire [1:0] snoop_bypass_select,
    input wire relaxed_order_disable,
    // transmit and request limits
    input wire [2:0] tx_payload_req,
    input wire [2:0] rd_req_size,
    input wire [2:0] rx_payload,
    // field outputs
    output reg [3:0] err_report_en,
    output reg relaxed_order_allow,
    output reg no_snoop_allow,
    output reg [2:0] max_payload,
    output reg [2:0] max_read_req,
    output reg [2:0] payload_cap,
    output reg tx_payload_ok,
    output reg rd_req_ok,
    output reg rx_payload_ok
);
    localparam [11:0] CTL_OFS = `OFS_DEVICE_CONTROL;
    reg [3:0] err_en_r;
    reg relaxed_en_r;
    reg [2:0] payload_r;
    reg ext_tag_r;
    reg phantom_r;
    reg no_snoop_r;
    reg [2:0] readreq_r;
    reg [3:0] err_det_r;
    reg [3:0] err_det_nxt;
    reg [2:0] cap_r;
    reg aux_power_r;
    wire aux_sync;
    wire hit;
    wire rd_hit;
    wire ctl_lo_wr;
    wire ctl_hi_wr;
    wire sts_clr_wr;
    wire [3:0] clr_mask;
    wire [31:0] rd_word;
    wire [15:0] ctl_word;
    wire [15:0] sts_word;
    wire [3:0] err_evt;

    ////////////////////////////////////////////////////////////////////////
    pin_sync #(
        .RESET_VAL(1'b0)
    ) u_aux_sync (
        .clock(clock),
        .rst(power_on_rst),
        .pin(aux_power_pin),
        .level_r(aux_sync)
    );

    // only the dword holding both registers decodes; low address bits ignored
    assign hit = cfg_req && (cfg_addr[11:2] == CTL_OFS[11:2]);
    assign rd_hit = hit && !cfg_wr;
    assign err_evt = {err_unsupported, err_fatal, err_nonfatal, err_corr};
    assign ctl_word = {1'b0, readreq_r, no_snoop_r, 1'b0, phantom_r, ext_tag_r,
                       payload_r, relaxed_en_r, err_en_r}; // R7 R16
    assign sts_word = {10'h000, np_pending, aux_power_r, err_det_r}; // R14 R16
    assign rd_word = {sts_word, ctl_word};

    ////////////////////////////////////////////////////////////////////////
    // byte lane strobes; lane 3 holds nothing writable
    assign ctl_lo_wr = hit && cfg_wr && cfg_be[0];
    assign ctl_hi_wr = hit && cfg_wr && cfg_be[1];
    assign sts_clr_wr = hit && cfg_wr && cfg_be[2];
    assign clr_mask = cfg_wdata[`STS_LANE_LO + `STS_UR:`STS_LANE_LO + `STS_CORR];

    ////////////////////////////////////////////////////////////////////////
    // aux power strap, only power-on reset touches it
    always @(posedge clock) begin
        if (power_on_rst) begin
            aux_power_r <= 1'b0;
        end else begin
            aux_power_r <= aux_sync; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capability, reset default then nvm load
    always @(posedge clock) begin
        if (rst) begin
            cap_r <= `RST_PAYLOAD_CAP; // R15
        end else if (nvm_cap_load) begin
            cap_r <= nvm_payload_cap; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always @(posedge clock) begin
        if (rst) begin
            err_en_r <= `RST_ERR_EN; // R1
            relaxed_en_r <= `RST_RELAXED_EN; // R2
            payload_r <= `RST_PAYLOAD; // R3
            ext_tag_r <= `RST_EXT_TAG; // R6
            phantom_r <= `RST_PHANTOM; // R6
            no_snoop_r <= `RST_NO_SNOOP; // R8
            readreq_r <= `RST_READREQ; // R9
        end else begin
            // payload field lies in lane 0, but its top bit 7 is written with the lane 1 strobe
            if (ctl_lo_wr) begin
                err_en_r <= cfg_wdata[`CTL_UR_EN:`CTL_CORR_EN]; // R1
                relaxed_en_r <= cfg_wdata[`CTL_RELAXED_EN]; // R2
                payload_r[0] <= cfg_wdata[`CTL_PAYLOAD_LO];
                payload_r[1] <= cfg_wdata[`CTL_PAYLOAD_LO + 1];
            end
            if (ctl_hi_wr) begin
                payload_r[2] <= cfg_wdata[`CTL_PAYLOAD_HI]; // R3
                ext_tag_r <= cfg_wdata[`CTL_EXT_TAG]; // R6
                phantom_r <= cfg_wdata[`CTL_PHANTOM]; // R6
                no_snoop_r <= cfg_wdata[`CTL_NO_SNOOP]; // R8
                readreq_r <= cfg_wdata[`CTL_READREQ_HI:`CTL_READREQ_LO]; // R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags, set wins over clear
    // an event in the clearing cycle keeps its flag set
    always @* begin
        err_det_nxt = err_det_r;
        if (sts_clr_wr) begin
            err_det_nxt = err_det_r & ~clr_mask; // R11 R12
        end
        err_det_nxt = err_det_nxt | err_evt; // R11 R12 R16
    end

    always @(posedge clock) begin
        if (rst) begin
            err_det_r <= 4'h0;
        end else begin
            err_det_r <= err_det_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config read port
    always @(posedge clock) begin
        if (rst) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            // every request is acknowledged, mapped or not
            cfg_ack <= cfg_req;
            if (rd_hit) begin
                cfg_rdata <= rd_word;
            end else begin
                cfg_rdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field outputs and limit checks
    always @(posedge clock) begin
        if (rst) begin
            err_report_en <= `RST_ERR_EN;
            relaxed_order_allow <= 1'b0;
            no_snoop_allow <= 1'b0;
            max_payload <= `RST_PAYLOAD;
            max_read_req <= `RST_READREQ;
            payload_cap <= `RST_PAYLOAD_CAP;
            tx_payload_ok <= 1'b0;
            rd_req_ok <= 1'b0;
            rx_payload_ok <= 1'b0;
        end else begin
            err_report_en <= err_en_r; // R1
            relaxed_order_allow <= relaxed_en_r && !relaxed_order_disable; // R2
            no_snoop_allow <= no_snoop_r && (snoop_bypass_select != 2'h0); // R8
            max_payload <= payload_r;
            max_read_req <= readreq_r; // R10
            payload_cap <= cap_r; // R5
            // sizes compare as encodings, a larger code is a larger size
            tx_payload_ok <= (tx_payload_req <= payload_r); // R3
            rd_req_ok <= (rd_req_size <= readreq_r); // R9
            rx_payload_ok <= (rx_payload <= payload_r); // R4
        end
    end
endmodule // pcie_device_control_status

/* File: test/pcie_device_control_status_assertions.sv */
// port-level checks of the device control/status register bank
// bound to the bank from the testbench top
`timescale 1ns/100ps
module pcie_device_control_status_assertions (
    // clock and reset
    input wire clock,
    input wire rst,
    // config port
    input wire cfg_req,
    input wire cfg_wr,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_rdata,
    input wire cfg_ack,
    // gates and limits
    input wire relaxed_order_disable,
    input wire relaxed_order_allow,
    input wire [1:0] snoop_bypass_select,
    input wire no_snoop_allow,
    input wire [2:0] tx_payload_req,
    input wire [2:0] max_payload,
    input wire tx_payload_ok,
    input wire [2:0] rd_req_size,
    input wire [2:0] max_read_req,
    input wire rd_req_ok,
    input wire [2:0] rx_payload,
    input wire rx_payload_ok
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ack_follows_req_a: assert property (!$past(rst) |-> cfg_ack == $past(cfg_req))
        else $error("ack does not follow request");
    tx_limit_a: assert property (!$past(rst) && $stable(max_payload) |->
        tx_payload_ok == ($past(tx_payload_req) <= max_payload)) else $error("tx limit wrong");
    rd_limit_a: assert property (!$past(rst) && $stable(max_read_req) |->
        rd_req_ok == ($past(rd_req_size) <= max_read_req)) else $error("read limit wrong");
    rx_limit_a: assert property (!$past(rst) && $stable(max_payload) |->
        rx_payload_ok == ($past(rx_payload) <= max_payload)) else $error("rx limit wrong");
    relaxed_gate_a: assert property (relaxed_order_allow |-> !$past(relaxed_order_disable))
        else $error("relaxed allowed while disabled");
    snoop_gate_a: assert property (no_snoop_allow |-> $past(snoop_bypass_select) != 2'h0)
        else $error("no snoop allowed without select");
    miss_reads_zero_a: assert property (cfg_req && (cfg_wr || cfg_addr[11:2] != 10'h3a)
        |=> cfg_rdata == 32'h0) else $error("data on miss or write");
    reserved_zero_a: assert property (cfg_ack |-> cfg_rdata[31:22] == 10'h0
        && !cfg_rdata[15] && !cfg_rdata[10]) else $error("reserved bit set");
    cover property (tx_payload_ok);
    cover property (rd_req_ok);
    cover property (cfg_ack && cfg_rdata[16]);
endmodule // pcie_device_control_status_assertions

/* File: test/cfg_host.sv */
// host configuration software model driving the config port
// assumes the bank acks each request on the following cycle
`timescale 1ns/100ps
module cfg_host (
    // clock
    input wire clock,
    // config port
    output reg cfg_req,
    output reg cfg_wr,
    output reg [11:0] cfg_addr,
    output reg [3:0] cfg_be,
    output reg [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    input wire cfg_ack
);
    initial {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = 50'h0;
    // callers keep payload within capability and read size fixed while reading
    task access(input w, input [11:0] a, input [3:0] b, input [31:0] d, output [31:0] q);
        begin
            @(negedge clock);
            {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, b, d};
            @(negedge clock);
            q = cfg_rdata;
            cfg_req = 1'b0;
            {cfg_addr, cfg_wdata} = ~{a, d};
        end
    endtask
endmodule // cfg_host

/* File: test/pcie_device_control_status_test.sv */
// self-checking bench of the device control/status register bank
// host model issues config accesses, bench drives events at falling edges
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module pcie_device_control_status_test;
    reg clock = 1'b0, rst = 1'b1, power_on_rst = 1'b1, aux_power_pin = 1'b0;
    reg np_pending = 1'b0, nvm_cap_load = 1'b0, relaxed_order_disable = 1'b0;
    reg [3:0] err = 4'h0;
    reg [2:0] nvm_payload_cap = 3'h1, tx_payload_req = 3'h0, rd_req_size = 3'h0;
    reg [2:0] rx_payload = 3'h0;
    reg [1:0] snoop_bypass_select = 2'h1;
    wire cfg_req, cfg_wr, cfg_ack, relaxed_order_allow, no_snoop_allow;
    wire tx_payload_ok, rd_req_ok, rx_payload_ok;
    wire [11:0] cfg_addr;
    wire [3:0] cfg_be, err_report_en;
    wire [31:0] cfg_wdata, cfg_rdata;
    wire [2:0] max_payload, max_read_req, payload_cap;
    reg [31:0] q;
    integer err_count = 0, checks_done = 0;
    always #50 clock = ~clock;
    cfg_host h (.clock, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack);
    pcie_device_control_status uut (.clock, .rst, .power_on_rst, .cfg_req, .cfg_wr, .cfg_addr,
        .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .err_corr(err[0]), .err_nonfatal(err[1]),
        .err_fatal(err[2]), .err_unsupported(err[3]), .aux_power_pin, .np_pending,
        .nvm_cap_load, .nvm_payload_cap, .snoop_bypass_select, .relaxed_order_disable,
        .tx_payload_req, .rd_req_size, .rx_payload, .err_report_en, .relaxed_order_allow,
        .no_snoop_allow, .max_payload, .max_read_req, .payload_cap, .tx_payload_ok,
        .rd_req_ok, .rx_payload_ok);
    task tick(input integer n); repeat (n) @(negedge clock); endtask
    task rd(input [11:0] a); h.access(1'b0, a, 4'hf, 32'h0, q); endtask
    task wr(input [3:0] b, input [31:0] d); h.access(1'b1, 12'h0e8, b, d, q); endtask
    task done(input [63:0] s); $display("test %0s done", s); endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #100000;
        err_count++;
        end_sim;
    end
    initial begin
        tick(2);
        {rst, power_on_rst} = 2'h0;
        rd(12'h0e8);
        `CHK("ctl_rst", 32'h0000_2810, q)
        `CHK("limits", 9'h011, {max_payload, max_read_req, payload_cap})
        `CHK("gates", 2'h3, {relaxed_order_allow, no_snoop_allow})
        done("reset");
        err = 4'hf;
        tick(1);
        err = 4'h0;
        rd(12'h0e8);
        `CHK("sts_set", 4'hf, q[19:16])
        wr(4'h4, 32'hffd5_0000);
        rd(12'h0e8);
        `CHK("sts_w1c", 8'h0a, q[23:16])
        wr(4'h3, 32'h0000_ff3f);
        rd(12'h0e8);
        `CHK("ctl_all", 16'h7b3f, q[15:0])
        `CHK("err_en", 4'hf, err_report_en)
        {relaxed_order_disable, snoop_bypass_select} = 3'h4;
        tick(2);
        `CHK("gated", 2'h0, {relaxed_order_allow, no_snoop_allow})
        done("regs");
        wr(4'h3, 32'h0000_1020);
        {tx_payload_req, rd_req_size, rx_payload} = 9'h091;
        tick(3);
        `CHK("oks_a", 3'h1, {tx_payload_ok, rd_req_ok, rx_payload_ok})
        {tx_payload_req, rd_req_size, rx_payload} = 9'h04a;
        tick(2);
        `CHK("oks_b", 3'h6, {tx_payload_ok, rd_req_ok, rx_payload_ok})
        done("limits");
        {np_pending, aux_power_pin} = 2'h3;
        tick(8);
        rd(12'h0e8);
        `CHK("sts_ro", 2'h3, q[21:20])
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        rd(12'h0e8);
        `CHK("aux_kept", 1'b1, q[20])
        power_on_rst = 1'b1;
        tick(1);
        power_on_rst = 1'b0;
        rd(12'h0e8);
        `CHK("aux_por", 1'b0, q[20])
        tick(6);
        rd(12'h0e8);
        `CHK("aux_back", 1'b1, q[20])
        rd(12'h0ec);
        `CHK("miss", 32'h0, q)
        `CHK("miss_ack", 1'b1, cfg_ack)
        nvm_payload_cap = 3'h0;
        nvm_cap_load = 1'b1;
        tick(1);
        nvm_cap_load = 1'b0;
        tick(2);
        `CHK("cap", 3'h0, payload_cap)
        done("status");
        end_sim;
    end
endmodule // pcie_device_control_status_test
bind pcie_device_control_status pcie_device_control_status_assertions chk (.clock, .rst,
    .cfg_req, .cfg_wr, .cfg_addr, .cfg_rdata, .cfg_ack, .relaxed_order_disable,
    .relaxed_order_allow, .snoop_bypass_select, .no_snoop_allow, .tx_payload_req,
    .max_payload, .tx_payload_ok, .rd_req_size, .max_read_req, .rd_req_ok, .rx_payload,
    .rx_payload_ok);
